// ===== hdl/adcrc_defines.svh
// Register map, field positions and reset values of the converter control
`ifndef ADCRC_DEFINES_SVH
`define ADCRC_DEFINES_SVH

// ----------------------------------------------------------------------
// Word index of each register (byte address is four times the index)
// ----------------------------------------------------------------------
`define ADCRC_IDX_INPUT_SELECT 3'h0
`define ADCRC_IDX_CONTROL_STATUS 3'h1
`define ADCRC_IDX_RESULT_LOW 3'h2
`define ADCRC_IDX_RESULT_HIGH 3'h3
`define ADCRC_IDX_IRQ_STATUS 3'h4
`define ADCRC_IDX_IRQ_MASK 3'h5

// ----------------------------------------------------------------------
// Input select fields
// ----------------------------------------------------------------------
`define ADCRC_SEL_REF_HI 7
`define ADCRC_SEL_REF_LO 6
`define ADCRC_SEL_ADJUST 5
`define ADCRC_SEL_CH_HI 3
`define ADCRC_SEL_CH_LO 0

// ----------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------
`define ADCRC_CSR_ENABLE 7
`define ADCRC_CSR_START 6
`define ADCRC_CSR_AUTO 5
`define ADCRC_CSR_FLAG 4
`define ADCRC_CSR_IE 3
`define ADCRC_CSR_DIV_HI 2
`define ADCRC_CSR_DIV_LO 0

// ----------------------------------------------------------------------
// Event bits of the interrupt status and mask registers
// ----------------------------------------------------------------------
`define ADCRC_EV_DONE 0
`define ADCRC_EV_LOST 1

// ----------------------------------------------------------------------
// Reset values and fillers
// ----------------------------------------------------------------------
`define ADCRC_RST_BYTE 8'h00
`define ADCRC_RST_CODE 10'h000
`define ADCRC_RST_REF 2'h0
`define ADCRC_RST_CH 4'h0
`define ADCRC_RST_DIV 3'h0
`define ADCRC_RST_EV 2'h0
`define ADCRC_RST_WORD 32'h0000_0000
`define ADCRC_PAD_LOW 6'h00
`define ADCRC_PAD_WORD 24'h00_0000
`define ADCRC_DIV_ZERO_CODE 3'h0
`define ADCRC_DIV_ONE 3'h1
`define ADCRC_CNT_ZERO 7'h00
`define ADCRC_CNT_ONE 7'h01

`endif

// ===== hdl/adcrc_pkg.sv
// Types shared by the converter control files
package adcrc_pkg;

  typedef logic [7:0] adcrc_byte_t;
  typedef logic [9:0] adcrc_code_t;
  typedef logic [1:0] adcrc_ref_t;
  typedef logic [3:0] adcrc_ch_t;
  typedef logic [1:0] adcrc_ev_t;

  typedef enum logic {
    ADCRC_BUS_IDLE,
    ADCRC_BUS_ACK
  } adcrc_bus_state_t;

endpackage

// ===== hdl/adcrc_prescaler.sv
// Converter clock tick generator from the system clock
`timescale 1ns/100ps
`default_nettype none
`include "adcrc_defines.svh"

module adcrc_prescaler (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [2:0] shift;
  logic [6:0] last;

  // ----------------------------------------------------------------------
  // Divisor: codes 0 and 1 both give 2, then doubling up to 128
  // ----------------------------------------------------------------------
  assign shift = (div_sel == `ADCRC_DIV_ZERO_CODE) ? `ADCRC_DIV_ONE : div_sel;
  assign last = 7'((`ADCRC_CNT_ONE << shift) - `ADCRC_CNT_ONE);
  assign tick = run && (cnt_q == last);
  assign cnt_d = (!run || tick) ? `ADCRC_CNT_ZERO : 7'(cnt_q + `ADCRC_CNT_ONE);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= `ADCRC_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/adcrc_top.sv
// Converter control: selection, start/busy, result formatting, bus slave
`timescale 1ns/100ps
`default_nettype none
`include "adcrc_defines.svh"

// Notes on behaviour
// - A finished conversion puts its 10-bit code, Vin*1024/Vref, in the result registers unless a low byte read is pending.
// - Code 000 is analog ground and code 3ff is the reference less one step.
// - Reference field 7:6 picks pin, supply, reserved or internal 1.1V reference.
// - Channel and reference writes during a conversion apply only once it completes.
// - The left-adjust bit reshapes the visible result at once, even mid-conversion.
// - Bit 4 of the input select register always reads as zero.
// - Channel codes 0-7 pick inputs, 8-13 are reserved, 14 bandgap, 15 ground.
// - The start bit reads one while converting, clears on completion unless auto mode restarts, zero writes do nothing.
// - The done flag sets on completion, clears on vector taken or on a written one.
// - After a low result byte read, results hold until the high byte is read.
// - The divider field divides the system clock by 2,2,4,8,...,128.
module adcrc_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic irq_vector_taken,
  output logic core_enable,
  output logic core_tick,
  output logic core_start,
  output logic [3:0] core_channel,
  output logic [1:0] core_reference,
  input wire logic core_done,
  input wire logic [9:0] core_code
);

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  adcrc_pkg::adcrc_bus_state_t bus_q;
  adcrc_pkg::adcrc_bus_state_t bus_d;
  logic req;
  logic capture;
  logic taken;
  logic [2:0] idx;

  assign req = avs_read || avs_write;
  assign idx = avs_address[4:2];
  // One wait cycle: read data are latched then, so they stand at the ack
  assign avs_waitrequest = req && (bus_q == adcrc_pkg::ADCRC_BUS_IDLE);
  assign capture = avs_read && (bus_q == adcrc_pkg::ADCRC_BUS_IDLE);
  assign taken = req && (bus_q == adcrc_pkg::ADCRC_BUS_ACK);

  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      adcrc_pkg::ADCRC_BUS_IDLE: begin
        if (req) begin
          bus_d = adcrc_pkg::ADCRC_BUS_ACK;
        end
      end
      adcrc_pkg::ADCRC_BUS_ACK: begin
        bus_d = adcrc_pkg::ADCRC_BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------------
  logic wr;
  logic wr_sel;
  logic wr_csr;
  logic wr_ists;
  logic wr_imsk;
  logic [7:0] wd;

  assign wr = taken && avs_write;
  assign wd = avs_writedata[7:0];
  assign wr_sel = wr && (idx == `ADCRC_IDX_INPUT_SELECT);
  assign wr_csr = wr && (idx == `ADCRC_IDX_CONTROL_STATUS);
  assign wr_ists = wr && (idx == `ADCRC_IDX_IRQ_STATUS);
  assign wr_imsk = wr && (idx == `ADCRC_IDX_IRQ_MASK);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  adcrc_pkg::adcrc_ref_t sel_ref_q;
  logic sel_adjust_q;
  adcrc_pkg::adcrc_ch_t sel_ch_q;
  adcrc_pkg::adcrc_ref_t act_ref_q;
  adcrc_pkg::adcrc_ch_t act_ch_q;
  logic en_q;
  logic auto_q;
  logic ie_q;
  logic [2:0] div_q;
  logic busy_q;
  logic busy_d;
  logic flag_q;
  logic flag_d;
  logic start_q;
  logic start_d;
  adcrc_pkg::adcrc_code_t result_q;
  logic lock_q;
  logic lock_d;
  adcrc_pkg::adcrc_ev_t ists_q;
  adcrc_pkg::adcrc_ev_t ists_d;
  adcrc_pkg::adcrc_ev_t imsk_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // ----------------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------------
  logic en_next;
  logic go;
  logic finish;
  logic restart;
  logic flag_clr;
  logic rd_low;
  logic rd_high;
  logic upd;
  logic lost;

  assign en_next = wr_csr ? wd[`ADCRC_CSR_ENABLE] : en_q;
  // Only a written one starts; a written zero leaves busy alone
  assign go = wr_csr && wd[`ADCRC_CSR_START] && en_next && !busy_q;
  assign finish = core_done && busy_q;
  // Free running: a finished conversion immediately starts the next one
  assign restart = finish && auto_q && en_q;
  assign start_d = go || restart;
  // Disabling aborts any conversion in progress
  always_comb begin
    busy_d = busy_q;
    if (!en_next) begin
      busy_d = 1'b0;
    end else if (go) begin
      busy_d = 1'b1;
    end else if (finish && !restart) begin
      busy_d = 1'b0;
    end
  end

  assign flag_clr = irq_vector_taken || (wr_csr && wd[`ADCRC_CSR_FLAG]);
  // A completion in the clearing cycle keeps the flag set
  assign flag_d = finish || (flag_q && !flag_clr);

  assign rd_low = capture && (idx == `ADCRC_IDX_RESULT_LOW);
  assign rd_high = capture && (idx == `ADCRC_IDX_RESULT_HIGH);
  assign lock_d = rd_low || (lock_q && !rd_high);
  // Blocked while the low byte is pending so both halves match
  assign upd = finish && !lock_q && !rd_low;
  assign lost = finish && !upd;

  assign ists_d = adcrc_pkg::adcrc_ev_t'({lost, finish}
    | (ists_q & ~(wr_ists ? wd[1:0] : `ADCRC_RST_EV)));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_q <= adcrc_pkg::ADCRC_BUS_IDLE;
      sel_ref_q <= `ADCRC_RST_REF;
      sel_adjust_q <= 1'b0;
      sel_ch_q <= `ADCRC_RST_CH;
      en_q <= 1'b0;
      auto_q <= 1'b0;
      ie_q <= 1'b0;
      div_q <= `ADCRC_RST_DIV;
      busy_q <= 1'b0;
      flag_q <= 1'b0;
      start_q <= 1'b0;
      lock_q <= 1'b0;
      ists_q <= `ADCRC_RST_EV;
      imsk_q <= `ADCRC_RST_EV;
      rdata_q <= `ADCRC_RST_WORD;
    end else begin
      bus_q <= bus_d;
      busy_q <= busy_d;
      flag_q <= flag_d;
      start_q <= start_d;
      lock_q <= lock_d;
      ists_q <= ists_d;
      rdata_q <= rdata_d;
      if (wr_sel) begin
        sel_ref_q <= wd[`ADCRC_SEL_REF_HI:`ADCRC_SEL_REF_LO];
        sel_adjust_q <= wd[`ADCRC_SEL_ADJUST];
        sel_ch_q <= wd[`ADCRC_SEL_CH_HI:`ADCRC_SEL_CH_LO];
      end
      if (wr_csr) begin
        en_q <= wd[`ADCRC_CSR_ENABLE];
        auto_q <= wd[`ADCRC_CSR_AUTO];
        ie_q <= wd[`ADCRC_CSR_IE];
        div_q <= wd[`ADCRC_CSR_DIV_HI:`ADCRC_CSR_DIV_LO];
      end
      if (wr_imsk) begin
        imsk_q <= wd[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Selection seen by the core and stored result
  // ----------------------------------------------------------------------
  // Tracks the written value while idle, frozen while converting
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      act_ref_q <= `ADCRC_RST_REF;
      act_ch_q <= `ADCRC_RST_CH;
    end else if (!busy_q || finish) begin
      act_ref_q <= sel_ref_q;
      act_ch_q <= sel_ch_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result_q <= `ADCRC_RST_CODE;
    end else if (upd) begin
      result_q <= core_code;
    end
  end

  // ----------------------------------------------------------------------
  // Result presentation and read mux
  // ----------------------------------------------------------------------
  adcrc_pkg::adcrc_byte_t res_low;
  adcrc_pkg::adcrc_byte_t res_high;
  adcrc_pkg::adcrc_byte_t sel_rd;
  adcrc_pkg::adcrc_byte_t csr_rd;
  adcrc_pkg::adcrc_byte_t rd_byte;

  // Combinational from the stored code so the adjust bit acts at once
  assign res_low = sel_adjust_q ? {result_q[1:0], `ADCRC_PAD_LOW}
    : result_q[7:0];
  assign res_high = sel_adjust_q ? result_q[9:2]
    : {`ADCRC_PAD_LOW, result_q[9:8]};
  assign sel_rd = {sel_ref_q, sel_adjust_q, 1'b0, sel_ch_q};
  assign csr_rd = {en_q, busy_q, auto_q, flag_q, ie_q, div_q};

  always_comb begin
    rd_byte = `ADCRC_RST_BYTE;
    unique case (idx)
      `ADCRC_IDX_INPUT_SELECT: rd_byte = sel_rd;
      `ADCRC_IDX_CONTROL_STATUS: rd_byte = csr_rd;
      `ADCRC_IDX_RESULT_LOW: rd_byte = res_low;
      `ADCRC_IDX_RESULT_HIGH: rd_byte = res_high;
      `ADCRC_IDX_IRQ_STATUS: rd_byte = {`ADCRC_PAD_LOW, ists_q};
      `ADCRC_IDX_IRQ_MASK: rd_byte = {`ADCRC_PAD_LOW, imsk_q};
      default: rd_byte = `ADCRC_RST_BYTE;
    endcase
  end

  assign rdata_d = capture ? {`ADCRC_PAD_WORD, rd_byte} : rdata_q;

  // ----------------------------------------------------------------------
  // Converter clock divider
  // ----------------------------------------------------------------------
  adcrc_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .run(en_q),
    .div_sel(div_q),
    .tick(core_tick)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign avs_readdata = rdata_q;
  assign irq = (|(ists_q & imsk_q)) || (flag_q && ie_q);
  assign core_enable = en_q;
  assign core_start = start_q;
  assign core_channel = act_ch_q;
  assign core_reference = act_ref_q;

endmodule
`default_nettype wire

// ===== tb/adcrc_asserts.sv
// Checker for bus handshake, core pulses and selection locking
`timescale 1ns/100ps
`default_nettype none
module adcrc_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic core_enable,
  input wire logic core_tick,
  input wire logic core_start,
  input wire logic [3:0] core_channel,
  input wire logic [1:0] core_reference,
  input wire logic core_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic busy_q;
  logic sel_wr;
  assign sel_wr = avs_write && !avs_waitrequest && avs_address[4:2] == 3'h0;
  // Own view of busy; enable drop aborts as the core would
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      busy_q <= 1'b0;
    else
      busy_q <= core_enable && (core_start || (busy_q && !core_done));
  end
  start_pulse_a: assert property (core_start |=> !core_start)
    else $error("start pulse longer than one cycle");
  start_en_a: assert property (core_start |-> core_enable)
    else $error("start while disabled");
  sel_hold_a: assert property (busy_q && !core_done |=>
    $stable(core_channel) && $stable(core_reference))
    else $error("selection moved during conversion");
  // Register write lands one edge, the active copy follows one edge later
  sel_track_a: assert property (sel_wr && !busy_q && !core_start |-> ##2
    core_channel == $past(avs_writedata[3:0], 2))
    else $error("idle channel write not applied");
  wait_one_a: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count wrong");
  wait_idle_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait without request");
  res_bit4_a: assert property (avs_read && !avs_waitrequest &&
    avs_address[4:2] == 3'h0 |-> !avs_readdata[4])
    else $error("unused select bit reads one");
  tick_gap_a: assert property (core_tick |=> !core_tick)
    else $error("converter tick faster than half rate");
  cover property (busy_q && core_done);
  cover property (sel_wr && busy_q);
  cover property (avs_read && !avs_waitrequest && avs_address[4:2] == 3'h3);
endmodule
`default_nettype wire

// ===== tb/adcrc_core_model.sv
// Behavioural analog core: answers a start after a number of ticks
`timescale 1ns/100ps
`default_nettype none
module adcrc_core_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic core_enable,
  input wire logic core_tick,
  input wire logic core_start,
  input wire logic [7:0] n_ticks,
  input wire logic [9:0] code_in,
  output logic core_done,
  output logic [9:0] core_code
);
  logic [7:0] left_q;
  logic [9:0] last_q;
  // No digital pin activity is modelled during conversion
  always @(posedge ref_clk or negedge resetn) begin
    core_done <= 1'b0;
    if (!resetn) begin
      left_q <= 8'h00;
      last_q <= 10'h000;
    end else if (!core_enable)
      left_q <= 8'h00;
    else if (core_start)
      left_q <= n_ticks;
    else if (core_tick && left_q == 8'h01) begin
      left_q <= 8'h00;
      core_done <= 1'b1;
      last_q <= code_in;
    end else if (core_tick && left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  // Code is only meaningful with done, so it is scrambled otherwise
  assign core_code = core_done ? last_q : ~last_q;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Register level testbench of the converter control
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic irq_vector_taken = 1'b0;
  logic [9:0] code_in = 10'h000;
  logic [7:0] n_ticks = 8'h28;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, irq, core_enable, core_tick, core_start, core_done;
  logic [3:0] core_channel;
  logic [1:0] core_reference;
  logic [9:0] core_code;
  logic [7:0] csr;
  int n_errors = 0;
  int checks = 0;
  int n;
  always #10 ref_clk = ~ref_clk;
  adcrc_top i_adcrc_top (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq),
    .irq_vector_taken(irq_vector_taken),
    .core_enable(core_enable),
    .core_tick(core_tick),
    .core_start(core_start),
    .core_channel(core_channel),
    .core_reference(core_reference),
    .core_done(core_done),
    .core_code(core_code)
  );
  adcrc_core_model i_adcrc_core_model (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .core_enable(core_enable),
    .core_tick(core_tick),
    .core_start(core_start),
    .n_ticks(n_ticks),
    .code_in(code_in),
    .core_done(core_done),
    .core_code(core_code)
  );
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    i = 0;
    // Values read here are those standing at this rising edge
    do begin
      @(posedge ref_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_errors++;
      close_out;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, {24'h00_0000, e});
  endtask
  // Polls busy; a slow core only costs polls, bounded all the same
  task automatic conv(input logic [9:0] c);
    int i;
    code_in <= c;
    wr8(5'h04, csr | 8'h40);
    i = 0;
    do begin
      bus(1'b0, 5'h04, 8'h00);
      i++;
    end while (rd[6] !== 1'b0 && i < 60);
    if (i >= 60) begin
      n_errors++;
      close_out;
    end
  endtask
  task automatic tick_gap(output int g);
    g = 0;
    do begin
      @(negedge ref_clk);
      g++;
    end while (core_tick !== 1'b1 && g < 300);
    if (g >= 300) begin
      n_errors++;
      close_out;
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    rchk("select", 5'h00, 8'h00);
    rchk("csr", 5'h04, 8'h00);
    wr8(5'h00, 8'hff);
    rchk("select", 5'h00, 8'hef);
    for (int k = 0; k < 16; k++) begin
      wr8(5'h00, {k[1:0], 2'b00, k[3:0]});
      // Active copy follows the register one edge after the write
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("sel", {core_reference, core_channel}, {k[1:0], k[3:0]});
    end
    csr = 8'h89;
    wr8(5'h04, csr);
    code_in <= 10'h3ff;
    wr8(5'h04, 8'hc9);
    rchk("busy", 5'h04, 8'hc9);
    wr8(5'h04, 8'h89);
    rchk("busy", 5'h04, 8'hc9);
    wr8(5'h00, 8'h45);
    @(negedge ref_clk);
    chk("hold", {core_reference, core_channel}, 6'h3f);
    conv(10'h3ff);
    chk("new", {core_reference, core_channel}, 6'h15);
    rchk("csr", 5'h04, 8'h99);
    chk("irq", irq, 1'b1);
    rchk("low", 5'h08, 8'hff);
    rchk("high", 5'h0c, 8'h03);
    @(posedge ref_clk);
    irq_vector_taken <= 1'b1;
    @(posedge ref_clk);
    irq_vector_taken <= 1'b0;
    rchk("csr", 5'h04, 8'h89);
    chk("irq", irq, 1'b0);
    rchk("status", 5'h10, 8'h01);
    wr8(5'h10, 8'h01);
    rchk("status", 5'h10, 8'h00);
    n_ticks <= 8'h01;
    conv(10'h2a5);
    wr8(5'h00, 8'h65);
    rchk("low", 5'h08, 8'h40);
    conv(10'h000);
    rchk("high", 5'h0c, 8'ha9);
    rchk("status", 5'h10, 8'h03);
    wr8(5'h10, 8'h03);
    wr8(5'h04, 8'h99);
    rchk("csr", 5'h04, 8'h89);
    conv(10'h000);
    rchk("low", 5'h08, 8'h00);
    rchk("high", 5'h0c, 8'h00);
    csr = 8'h81;
    wr8(5'h04, 8'h91);
    wr8(5'h14, 8'h01);
    rchk("mask", 5'h14, 8'h01);
    conv(10'h155);
    chk("irq", irq, 1'b1);
    wr8(5'h10, 8'h03);
    @(negedge ref_clk);
    chk("irq", irq, 1'b0);
    wr8(5'h18, 8'hff);
    rchk("unmapped", 5'h18, 8'h00);
    for (int d = 0; d < 8; d++) begin
      wr8(5'h04, 8'h80 | d[7:0]);
      tick_gap(n);
      tick_gap(n);
      tick_gap(n);
      chk("divide", n, (d < 2) ? 2 : (1 << d));
    end
    close_out;
  end
endmodule
bind adcrc_top adcrc_asserts i_adcrc_asserts (.*);
`default_nettype wire
